// *** rtl/rcs_map.vh ***
// Purpose: Constants for the reset cause and startup sequencer
// Assumes: 20 MHz clock, AXI4-Lite register access
// Notes: Offsets are byte addresses
`ifndef RCS_MAP_VH
`define RCS_MAP_VH
`define RCS_CAUSE_OFF 8'h00
`define RCS_CFG_OFF 8'h04
`define RCS_STAT_OFF 8'h08
`define RCS_BIT_TRAP 15
`define RCS_BIT_ILL 14
`define RCS_BIT_VREG 8
`define RCS_BIT_PIN 7
`define RCS_BIT_SWR 6
`define RCS_BIT_WDEN 5
`define RCS_BIT_WATCHDOG_TIMEOUT_FLAG 4
`define RCS_BIT_SLP 3
`define RCS_BIT_IDL 2
`define RCS_BIT_BOR 1
`define RCS_BIT_POR 0
`define RCS_CAUSE_MASK 16'hC1FF
`define RCS_CAUSE_POR_VAL 16'h0003
`define RCS_BOR_KEEP 16'h01A0
`define RCS_CLK_MHZ 20
`define RCS_POWERON_EXTENSION_US 30
`define RCS_BROWNOUT_EXTENSION_US 100
`define RCS_MONITOR_START_DELAY_US 900
`define RCS_TLOCK_US 1500
`define RCS_POWERON_EXTENSION_CYC ((`RCS_POWERON_EXTENSION_US * `RCS_CLK_MHZ))
`define RCS_BROWNOUT_EXTENSION_CYC ((`RCS_BROWNOUT_EXTENSION_US * `RCS_CLK_MHZ))
`define RCS_MONITOR_START_DELAY_CYC ((`RCS_MONITOR_START_DELAY_US * `RCS_CLK_MHZ))
`define RCS_TLOCK_CYC ((`RCS_TLOCK_US * `RCS_CLK_MHZ))
`define RCS_OST_CYC 1024
`define RCS_POWERUP_TIMER_MS_CYC 20000
`define RCS_RESET_VECTOR 24'h000000
`endif

// *** rtl/rcs_sequencer.v ***
// Purpose: Reset cause recording and startup sequencing
// Assumes: Inputs synchronous to clk; events are one-cycle pulses
// Notes: Oscillator clock timers are modelled in clk cycles
//   Modes without a crystal or a PLL skip those wait states entirely
// Behaviour
// - Trap conflict reset sets bit 15
// - Illegal op or pointer reset sets bit 14
// - Bits 13 to 9 read zero
// - Bit 8 keeps regulator on in sleep
// - Pin reset sets bit 7
// - Software reset instruction sets bit 6
// - Bit 5 enables watchdog unless fuse set
// - Watchdog timeout sets bit 4
// - Sleep sets bit 3, idle bit 2
// - Brown-out sets bit 1, also after power-on
// - Power-on sets bit 0
// - Software writes flags; never causes reset
// - Cold reset picks boot oscillator select
// - Warm reset keeps current oscillator select
// - Hold reset until supplies and clock ready
// - Crystal modes wait 1024 oscillator periods
// - PLL modes wait lock; external adds none
// - Power-up timer holds reset after brown-out
// - Execution starts at address zero
// - Clock monitor starts after its delay
// - Power-on reset extended by its time
// - Brown-out reset extended by its time
// - Power-on clears all flags but bits 0 and 1
// - Sleep or watchdog-clear instruction clears timeout
`include "rcs_map.vh"
`timescale 1ns/1ps
`default_nettype none
module rcs_sequencer #(
  parameter POWERON_EXTENSION_CYC = `RCS_POWERON_EXTENSION_CYC,
  parameter BROWNOUT_EXTENSION_CYC = `RCS_BROWNOUT_EXTENSION_CYC,
  parameter MONITOR_START_DELAY_CYC = `RCS_MONITOR_START_DELAY_CYC,
  parameter TLOCK_CYC = `RCS_TLOCK_CYC,
  parameter POWERUP_TIMER_MS_CYC = `RCS_POWERUP_TIMER_MS_CYC
) (
  input wire clk,
  input wire srst,
  input wire por_event,
  input wire bor_event,
  input wire pin_event,
  input wire swr_event,
  input wire watchdog_timeout_flag_event,
  input wire trap_event,
  input wire illegal_event,
  input wire sleep_event,
  input wire idle_event,
  input wire wdt_clear_event,
  input wire supply_ok,
  input wire watchdog_fuse_enable,
  input wire monitor_enable,
  input wire [2:0] boot_osc_select,
  input wire [2:0] current_osc_select,
  input wire [2:0] powerup_sel,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg system_reset_line,
  output reg [2:0] osc_select_out,
  output reg osc_enable,
  output reg [23:0] fetch_addr,
  output reg fetch_start,
  output reg monitor_active,
  output reg watchdog_enabled,
  output reg regulator_standby
);
  // Oscillator mode codes on the select bits
  localparam [2:0] OSC_FRC = 3'h0;
  localparam [2:0] OSC_FRCPLL = 3'h1;
  localparam [2:0] OSC_XT = 3'h2;
  localparam [2:0] OSC_HS = 3'h3;
  localparam [2:0] OSC_EC = 3'h4;
  localparam [2:0] OSC_XTPLL = 3'h5;
  localparam [2:0] OSC_HSPLL = 3'h6;
  localparam [2:0] OSC_ECPLL = 3'h7;
  // Sequencer states
  localparam [2:0] S_EXT = 3'h0;
  localparam [2:0] S_POWERUP_TIMER = 3'h1;
  localparam [2:0] S_OST = 3'h2;
  localparam [2:0] S_LOCK = 3'h3;
  localparam [2:0] S_RUN = 3'h4;
  localparam [2:0] S_MON = 3'h5;
  localparam [2:0] S_WARM = 3'h6;

  // Cause flags, sequencer state and its shared timer
  reg [15:0] cause_ff;
  reg [15:0] nxt_cause;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [31:0] cnt_ff;
  reg [31:0] nxt_cnt;
  reg cold_ff;
  reg [2:0] sel_ff;
  reg [2:0] nxt_sel;
  // Write address and data are held until both have arrived
  reg aw_hold_ff;
  reg w_hold_ff;
  reg [31:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [1:0] wstrb_lo_ff;
  wire wr_go;
  wire is_cold;
  wire warm_ev;
  wire [31:0] powerup_timer_cyc;
  wire crystal;
  wire pll;
  wire [7:0] stat_byte;

  assign is_cold = por_event | bor_event;
  assign warm_ev = pin_event | swr_event | watchdog_timeout_flag_event | trap_event | illegal_event;
  assign wr_go = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
  // Power-up delay is 0 or 2^(n-1) ms, giving eight settings up to 64 ms
  // A shift keeps the table out of logic; setting 1 is the unshifted base
  assign powerup_timer_cyc = (powerup_sel == 3'h0) ? 32'h0 :
    (POWERUP_TIMER_MS_CYC << (powerup_sel - 3'h1));
  assign crystal = (sel_ff == OSC_XT) | (sel_ff == OSC_HS) |
    (sel_ff == OSC_XTPLL) | (sel_ff == OSC_HSPLL);
  assign pll = (sel_ff == OSC_FRCPLL) | (sel_ff == OSC_XTPLL) |
    (sel_ff == OSC_HSPLL) | (sel_ff == OSC_ECPLL);
  // Status byte: select, monitor, reset line and sequencer state.
  // Read only; it shows software where a start-up has stalled.
  assign stat_byte = {sel_ff, monitor_active, system_reset_line, state_ff};

  //////////////////////////////////////////////////////////////////////////////
  // Cause register: hardware sets win over software writes in the same cycle
  // An event must never be lost to a racing write; software can still
  // clear the flag afterwards. Only the exact cause address writes here.
  always @* begin
    nxt_cause = cause_ff;
    if (wr_go && awaddr_ff == {24'h0, `RCS_CAUSE_OFF}) begin
      // Plain storage only; no reset path is taken from here
      if (wstrb_lo_ff[0]) nxt_cause[7:0] = wdata_ff[7:0];
      if (wstrb_lo_ff[1]) nxt_cause[15:8] = wdata_ff[15:8];
    end
    if (sleep_event || wdt_clear_event) nxt_cause[`RCS_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
    if (trap_event) nxt_cause[`RCS_BIT_TRAP] = 1'b1;
    if (illegal_event) nxt_cause[`RCS_BIT_ILL] = 1'b1;
    if (pin_event) nxt_cause[`RCS_BIT_PIN] = 1'b1;
    if (swr_event) nxt_cause[`RCS_BIT_SWR] = 1'b1;
    if (watchdog_timeout_flag_event) nxt_cause[`RCS_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
    if (sleep_event) nxt_cause[`RCS_BIT_SLP] = 1'b1;
    if (idle_event) nxt_cause[`RCS_BIT_IDL] = 1'b1;
    if (bor_event) begin
      // Brown-out clears history flags like power-on; pin flag survives
      nxt_cause = nxt_cause & `RCS_BOR_KEEP;
      nxt_cause[`RCS_BIT_BOR] = 1'b1;
    end
    if (por_event) begin
      nxt_cause = `RCS_CAUSE_POR_VAL;
    end
    nxt_cause = nxt_cause & `RCS_CAUSE_MASK;
  end

  always @(posedge clk) begin
    if (srst) begin
      cause_ff <= `RCS_CAUSE_POR_VAL;
    end else begin
      cause_ff <= nxt_cause;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Startup sequencer
  // Cold path: extension, power-up hold, then only the waits that the
  // selected oscillator mode needs. A state that the mode does not use
  // is skipped outright, so such a mode gains no extra cycle of reset.
  // Warm path: one cycle of reset on the clock that is already running.
  // The counter restarts at zero on every state change except S_RUN to S_MON.
  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 32'h1;
    nxt_sel = sel_ff;
    case (state_ff)
      S_EXT: begin
        // Extension counts only while supplies are reported good; a dip
        // restarts it, so a noisy supply never shortens the hold
        if (!supply_ok) begin
          nxt_cnt = 32'h0;
        end else if (cnt_ff + 32'h1 >= (cold_ff ? BROWNOUT_EXTENSION_CYC : POWERON_EXTENSION_CYC)) begin
          nxt_state = S_POWERUP_TIMER;
          nxt_cnt = 32'h0;
        end
      end
      S_POWERUP_TIMER: begin
        // The oscillator stays stopped until this hold is over
        if (cnt_ff >= powerup_timer_cyc) begin
          nxt_cnt = 32'h0;
          if (crystal) begin
            nxt_state = S_OST;
          end else if (pll) begin
            nxt_state = S_LOCK;
          end else begin
            // External clock or internal RC without PLL: no start-up wait
            nxt_state = S_RUN;
          end
        end
      end
      S_OST: begin
        // Crystal start-up count, oscillator periods taken as clk cycles
        if (cnt_ff + 32'h1 >= `RCS_OST_CYC) begin
          nxt_cnt = 32'h0;
          if (pll) begin
            nxt_state = S_LOCK;
          end else begin
            nxt_state = S_RUN;
          end
        end
      end
      S_LOCK: begin
        // Lock is timed, not sensed: the block has no lock input
        if (cnt_ff + 32'h1 >= TLOCK_CYC) begin
          nxt_state = S_RUN;
          nxt_cnt = 32'h0;
        end
      end
      S_RUN: begin
        // Running; the clock monitor start is held off by its own delay,
        // and with the monitor disabled the sequencer simply stays here
        if (monitor_enable && cnt_ff + 32'h1 >= MONITOR_START_DELAY_CYC) begin
          nxt_state = S_MON;
        end
      end
      S_MON: begin
        // Counter frozen; nothing further to time until the next reset
        nxt_cnt = cnt_ff;
      end
      S_WARM: begin
        // Warm reset releases after one cycle on the same clock
        nxt_state = S_RUN;
        nxt_cnt = 32'h0;
      end
      default: begin
        // Unused codes fall back to a full cold start
        nxt_state = S_EXT;
        nxt_cnt = 32'h0;
      end
    endcase
    // Reset sources override any state; a cold source wins over a warm
    // one in the same cycle because it restarts every timer
    if (is_cold) begin
      nxt_state = S_EXT;
      nxt_cnt = 32'h0;
      nxt_sel = boot_osc_select;
    end else if (warm_ev) begin
      nxt_state = S_WARM;
      nxt_cnt = 32'h0;
      nxt_sel = current_osc_select;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      state_ff <= S_EXT;
      cnt_ff <= 32'h0;
      cold_ff <= 1'b0;
      sel_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sel_ff <= nxt_sel;
      if (is_cold) cold_ff <= bor_event & ~por_event;
    end
  end

  // Outputs registered from next-state values, so each port changes on the
  // same edge as the state that it reports and comes straight from a flop.
  // The oscillator only runs once the power-up hold is over.
  always @(posedge clk) begin
    if (srst) begin
      system_reset_line <= 1'b1;
      osc_select_out <= 3'h0;
      osc_enable <= 1'b0;
      fetch_addr <= `RCS_RESET_VECTOR;
      fetch_start <= 1'b0;
      monitor_active <= 1'b0;
      watchdog_enabled <= 1'b1;
      regulator_standby <= 1'b1;
    end else begin
      system_reset_line <= (nxt_state == S_EXT) || (nxt_state == S_POWERUP_TIMER) ||
        (nxt_state == S_WARM) || (nxt_state == S_OST) || (nxt_state == S_LOCK);
      osc_enable <= (nxt_state != S_EXT) && (nxt_state != S_POWERUP_TIMER);
      osc_select_out <= nxt_sel;
      fetch_addr <= `RCS_RESET_VECTOR;
      fetch_start <= (nxt_state == S_RUN) && (state_ff != S_RUN);
      monitor_active <= (nxt_state == S_MON);
      watchdog_enabled <= watchdog_fuse_enable | nxt_cause[`RCS_BIT_WDEN];
      regulator_standby <= ~nxt_cause[`RCS_BIT_VREG];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; address and data captured independently
  // Each ready pulses for one cycle per beat; a new write is not answered
  // until the previous response has been taken by the master.
  always @(posedge clk) begin
    if (srst) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 32'h0;
      wdata_ff <= 32'h0;
      wstrb_lo_ff <= 2'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= ~aw_hold_ff & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_hold_ff & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_lo_ff <= s_axi_wstrb[1:0];
      end
      if (wr_go) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_ff == {24'h0, `RCS_CAUSE_OFF}) ?
          2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: cause word and a sequencer status word
  // Read data is sampled from the flops at the handshake, so a flag set
  // in the same cycle shows on the next read, never half-updated.
  always @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        if (s_axi_araddr == {24'h0, `RCS_CAUSE_OFF}) begin
          s_axi_rdata <= {16'h0, cause_ff};
        end else if (s_axi_araddr == {24'h0, `RCS_STAT_OFF}) begin
          s_axi_rdata <= {24'h0, stat_byte};
        end else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/rcs_sequencer_chk.sv ***
// Purpose: Port checks for the reset sequencer
// Assumes: One clock, srst synchronous active high
// Notes: Timer lengths are checked as lower bounds
`timescale 1ns/1ps
`default_nettype none
module rcs_chk (
  input wire clk,
  input wire srst,
  input wire por_event,
  input wire swr_event,
  input wire supply_ok,
  input wire watchdog_fuse_enable,
  input wire s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire system_reset_line,
  input wire [23:0] fetch_addr,
  input wire fetch_start,
  input wire monitor_active,
  input wire watchdog_enabled
);
  // One domain, so clock and reset are named once
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  // Cold resets hold the line; warm ones let go within a few cycles
  a_por_ext: assert property ($rose(por_event) |-> ##2 system_reset_line [*4])
    else $error("power-on hold too short");
  a_warm_short: assert property (swr_event && !system_reset_line |->
    ##[1:3] system_reset_line ##[1:4] !system_reset_line) else $error("warm reset wrong");
  a_supply_hold: assert property (system_reset_line && !supply_ok |=> system_reset_line)
    else $error("left reset with supply low");
  // Execution start and clock supervision start
  a_vec_addr: assert property (fetch_start |->
    fetch_addr == 24'h000000 && !system_reset_line) else $error("fetch off vector");
  a_run_fetch: assert property ($fell(system_reset_line) |-> ##[0:1] fetch_start)
    else $error("no fetch at run entry");
  a_mon_late: assert property ($rose(monitor_active) |-> !$past(system_reset_line, 4))
    else $error("monitor started early");
  // Control bits and unimplemented bits
  a_wdog_fuse: assert property (watchdog_fuse_enable |=> watchdog_enabled)
    else $error("fuse did not force watchdog");
  a_gap_zero: assert property (s_axi_rvalid |-> s_axi_rdata[13:9] == 5'h00)
    else $error("gap bits set");
  c_run: cover property (fetch_start);
  c_mon: cover property ($rose(monitor_active));
  c_read: cover property (s_axi_rvalid);
endmodule
////////////////////////////////////////
bind rcs_sequencer rcs_chk u_chk (
  .clk(clk), .srst(srst), .por_event(por_event), .swr_event(swr_event),
  .supply_ok(supply_ok), .watchdog_fuse_enable(watchdog_fuse_enable),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .system_reset_line(system_reset_line), .fetch_addr(fetch_addr),
  .fetch_start(fetch_start), .monitor_active(monitor_active),
  .watchdog_enabled(watchdog_enabled));
`default_nettype wire

// *** test/rcs_sequencer_bench.sv ***
// Purpose: Self-checking bench for rcs_sequencer
// Assumes: Short timer parameters
// Notes: Start-up delays compared as differences to an FRC start
`timescale 1ns/1ps
`default_nettype none
module rcs_sequencer_bench;
  localparam int L = 16, O = 1024, P = 10, F = 20;
  logic clk, srst, sok, fuse, men, awvalid, wvalid, bready, arvalid, rready;
  logic [9:0] ev;
  logic [2:0] boot, cur, psel;
  logic [31:0] awaddr, wdata, araddr;
  logic [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, srl, mon, wde, stby, oen;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] osel;
  int fails, n_compared, cyc, n, base;
  // Cold rows: boot select, power-up setting, extra cycles over FRC
  logic [2:0] osc [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 0, 0};
  logic [2:0] ps [10] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 3};
  int xtra [10] = '{0, L, O, O, 0, O + L, O + L, L, P, 4 * P};
  // All rows: event, cause before it, cause after it
  int evi [19] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 2, 3, 4, 5, 6, 7, 8, 9, 7};
  logic [15:0] pre [19] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
    16'h0, 16'h10, 16'h10};
  logic [15:0] cause [19] = '{16'h3, 16'h3, 16'h3, 16'h3, 16'h3, 16'h3, 16'h3, 16'h3,
    16'h3, 16'h3, 16'h80, 16'h40, 16'h10, 16'h8000, 16'h4000, 16'h8, 16'h4, 16'h0, 16'h8};
  rcs_sequencer #(.POWERON_EXTENSION_CYC(8), .BROWNOUT_EXTENSION_CYC(12), .MONITOR_START_DELAY_CYC(F), .TLOCK_CYC(L),
    .POWERUP_TIMER_MS_CYC(P)) uut (
    .clk(clk), .srst(srst), .por_event(ev[0]), .bor_event(ev[1]), .pin_event(ev[2]),
    .swr_event(ev[3]), .watchdog_timeout_flag_event(ev[4]), .trap_event(ev[5]), .illegal_event(ev[6]),
    .sleep_event(ev[7]), .idle_event(ev[8]), .wdt_clear_event(ev[9]), .supply_ok(sok),
    .watchdog_fuse_enable(fuse), .monitor_enable(men), .boot_osc_select(boot),
    .current_osc_select(cur), .powerup_sel(psel), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .system_reset_line(srl), .osc_select_out(osel),
    .osc_enable(oen), .fetch_addr(), .fetch_start(), .monitor_active(mon),
    .watchdog_enabled(wde), .regulator_standby(stby));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      wrap_up;
    end
  end
  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Each channel is released at its own handshake
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'h7};
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    r = bresp;
  endtask
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    cmp({rresp, rdata}, e);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= 10'h000;
  endtask
  // The first edges are skipped so the line has time to rise
  task automatic run_wait;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (srl !== 1'b0 || n < 3);
    cmp(oen, 1'b1);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, fuse, ev, boot, psel} = '0;
    {awaddr, wdata, araddr} = '0;
    {srst, sok, cur} = 5'h1D;
    men = 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 19; i++) begin
      if (i < 10) begin
        boot <= osc[i];
        psel <= ps[i];
      end
      wr(32'h0, {16'h0, pre[i]});
      pulse(evi[i]);
      if (i < 10) begin
        run_wait;
        if (i == 0) base = n;
        cmp(n - base, xtra[i]);
        n = 0;
        while (mon !== 1'b1 && n < 99) begin
          @(posedge clk);
          n++;
        end
        cmp(n >= F - 2 && n <= F + 2, 1);
      end else
        repeat (6) @(posedge clk);
      cmp(osel, i < 10 ? osc[i] : cur);
      rd(32'h0, {18'h0, cause[i]});
      $display("row %0d done", i);
    end
    // Flags are plain read/write; control bits reach their outputs
    wr(32'h0, 32'hFFFF);
    rd(32'h0, 34'hC1FF);
    cmp({wde, stby}, 2'h2);
    wr(32'h0, 32'h0);
    rd(32'h0, 34'h0);
    cmp({wde, stby}, 2'h1);
    fuse <= 1'b1;
    rd(32'hC, {2'h2, 32'h0});
    cmp(wde, 1'b1);
    wr(32'h10, 32'h1);
    cmp(r, 2'h2);
    $display("regs done");
    // Brown-out with the supply still low must wait, then restart cold
    wr(32'h0, 32'hC1E0);
    sok <= 1'b0;
    pulse(1);
    repeat (30) @(posedge clk);
    cmp(srl, 1'b1);
    cmp(oen, 1'b0);
    sok <= 1'b1;
    run_wait;
    cmp(osel, boot);
    rd(32'h0, 34'h1A2);
    $display("brown-out done");
    // Mid-run reset with the clock monitor disabled: it must never start
    men <= 1'b0;
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(32'h0, 34'h3);
    cmp(srl, 1'b1);
    run_wait;
    repeat (F + 4) @(posedge clk);
    cmp(mon, 1'b0);
    $display("reset done");
    wrap_up;
  end
endmodule
`default_nettype wire
